//--- rtl/drbs_regs.svh
// constants of the refresh bank scheduler: command encodings and refresh timings
`ifndef DRBS_REGS_SVH
`define DRBS_REGS_SVH

// ==========================================================================
// command encodings on ca[4:0], all-bank select on ca5, at the first edge, cs high
`define DRBS_REF_CA_CODE 5'h08
`define DRBS_ACT_CA_BIT 0
`define DRBS_PRE_CA_CODE 5'h10
`define DRBS_ALLBANK_CA_BIT 5

// ==========================================================================
// timing in ns and derived cycle counts at 50 ns per clock (least times round up)
`define DRBS_CLK_PERIOD_NS 50
`define DRBS_T_RFCAB_NS 280
`define DRBS_T_RFCPB_NS 140
`define DRBS_RFCAB_CYC ((`DRBS_T_RFCAB_NS + `DRBS_CLK_PERIOD_NS - 1) / `DRBS_CLK_PERIOD_NS)
`define DRBS_RFCPB_CYC ((`DRBS_T_RFCPB_NS + `DRBS_CLK_PERIOD_NS - 1) / `DRBS_CLK_PERIOD_NS)

// ==========================================================================
// reset values and bank count
`define DRBS_BANK_CNT_RST 3'h0
`define DRBS_ROW_CNT_RST 16'h0000
`define DRBS_NUM_BANKS 8

`endif

//--- rtl/drbs_pkg.sv
// types shared by the refresh bank scheduler files
package drbs_pkg;
    typedef enum logic [2:0] {
        DRBS_IDLE = 3'b001,
        DRBS_CAP2 = 3'b010,
        DRBS_DONE = 3'b100
    } drbs_dec_state_type;

    typedef enum logic [1:0] {
        DRBS_BK_IDLE = 2'h0,
        DRBS_BK_ACTIVE = 2'h1,
        DRBS_BK_REFRESH = 2'h2
    } drbs_bank_state_type;
endpackage : drbs_pkg

//--- rtl/drbs_bank_timer.sv
// per-bank refresh busy timer: holds one bank inaccessible for a cycle count
`timescale 1ns/1ps
`include "drbs_regs.svh"

module drbs_bank_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] count_i,
    output logic busy_o,
    output logic done_o
);
    logic [3:0] cnt_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 4'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_reg <= count_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (cnt_reg == 4'h1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : drbs_bank_timer

//--- rtl/drbs_refresh_sched.sv
// device-side refresh bookkeeping: command decode, bank and row counters, bank states
`timescale 1ns/1ps
`include "drbs_regs.svh"

// Overview of operation
// RQ1 - controller refreshes only idle banks; all-bank refresh never with any row open
// RQ2 - controller mirrors the bank count of each per-bank refresh
// RQ3 - per-bank refresh waits all-bank cycle time after the last all-bank refresh
// RQ4 - per-bank refresh waits per-bank cycle time after the last per-bank refresh
// RQ5 - per-bank refresh waits precharge period and activate-to-activate delay
// RQ6 - only the target bank is inaccessible during its per-bank refresh
// RQ7 - refreshed bank returns to idle when its per-bank cycle ends
// RQ8 - all-bank refresh waits per-bank cycle time after a per-bank refresh
// RQ9 - activate to same bank waits per-bank cycle time after its refresh
// RQ10 - activate to other bank waits activate-to-activate delay after per-bank refresh
// RQ11 - next per-bank refresh waits per-bank cycle time
// RQ12 - all banks idle before an all-bank refresh
// RQ13 - all-bank refresh clears the per-bank refresh counter
// RQ14 - all-bank refresh waits all-bank, per-bank and precharge times
// RQ15 - all banks idle when the all-bank refresh cycle completes
// RQ16 - activate waits all-bank cycle time after all-bank refresh
// RQ17 - any refresh waits all-bank cycle time after all-bank refresh
// RQ18 - bank counter cleared on reset, self-refresh exit and all-bank refresh
// RQ19 - 3-bit bank counter wraps 7 to 0; row counter advances after eight
// RQ20 - refresh code: cs high, ca0-4 low low low high low, ca5 selects all-bank
// RQ21 - per-bank target bank bits 0..2 on ca0..ca2 at the second edge
// RQ22 - controller refreshes each of eight banks once before repeating any
// RQ23 - all-bank refresh at nonzero count clears it; next refresh uses row plus one
module drbs_refresh_sched (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_i,
    input wire logic [5:0] ca_i,
    input wire logic self_refresh_exit_i,
    output logic [2:0] bank_count_o,
    output logic [15:0] row_count_o,
    output logic [7:0] bank_busy_o,
    output logic [7:0] bank_active_o,
    output logic all_bank_busy_o,
    output logic refresh_done_o
);
    drbs_pkg::drbs_dec_state_type dec_reg;
    logic per_bank_pend_reg;
    logic [2:0] bank_count_reg;
    logic [15:0] row_count_reg;
    logic [2:0] target_bank_reg;
    logic [7:0] pb_start;
    logic [7:0] pb_busy;
    logic [7:0] pb_done;
    logic [3:0] ab_cnt_reg;
    logic per_bank_refresh_cmd;
    logic all_bank_refresh_cmd;
    logic ref_first;
    logic act_first;
    logic pre_first;

    // ======================================================================
    // first-edge decode; second edge of a two-edge command is captured below
    assign ref_first = cs_i && (ca_i[4:0] == `DRBS_REF_CA_CODE)
        && (dec_reg == drbs_pkg::DRBS_IDLE); // [RQ20]
    assign act_first = cs_i && ca_i[`DRBS_ACT_CA_BIT] && (dec_reg == drbs_pkg::DRBS_IDLE);
    assign pre_first = cs_i && (ca_i[4:0] == `DRBS_PRE_CA_CODE)
        && (dec_reg == drbs_pkg::DRBS_IDLE);
    assign all_bank_refresh_cmd = ref_first && ca_i[`DRBS_ALLBANK_CA_BIT]; // [RQ20]
    assign per_bank_refresh_cmd = (dec_reg == drbs_pkg::DRBS_CAP2) && per_bank_pend_reg;

    // ======================================================================
    // two-edge command tracker
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_reg <= drbs_pkg::DRBS_IDLE;
            per_bank_pend_reg <= 1'b0;
        end else begin
            case (dec_reg)
                drbs_pkg::DRBS_IDLE: begin
                    if (ref_first || act_first || pre_first) begin
                        dec_reg <= drbs_pkg::DRBS_CAP2;
                        per_bank_pend_reg <= ref_first && !ca_i[`DRBS_ALLBANK_CA_BIT];
                    end
                end
                drbs_pkg::DRBS_CAP2: begin
                    dec_reg <= drbs_pkg::DRBS_DONE;
                    per_bank_pend_reg <= 1'b0;
                end
                default: begin
                    dec_reg <= drbs_pkg::DRBS_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // bank counter and row counter; self-refresh exit takes priority, then all-bank refresh
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_count_reg <= `DRBS_BANK_CNT_RST; // [RQ18]
            row_count_reg <= `DRBS_ROW_CNT_RST;
        end else if (self_refresh_exit_i) begin
            bank_count_reg <= `DRBS_BANK_CNT_RST; // [RQ18]
        end else if (all_bank_refresh_cmd) begin
            // refreshes at the current row, so the next refresh sees row plus one
            bank_count_reg <= `DRBS_BANK_CNT_RST; // [RQ13] [RQ23]
            row_count_reg <= row_count_reg + 16'h0001; // [RQ23]
        end else if (per_bank_refresh_cmd) begin
            bank_count_reg <= bank_count_reg + 3'h1; // [RQ19]
            if (bank_count_reg == 3'h7) begin
                row_count_reg <= row_count_reg + 16'h0001; // [RQ19]
            end
        end
    end

    // ======================================================================
    // target bank from ca0..ca2 on the second edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_bank_reg <= 3'h0;
        end else if (per_bank_refresh_cmd) begin
            target_bank_reg <= {ca_i[2], ca_i[1], ca_i[0]}; // [RQ21]
        end
    end

    // ======================================================================
    // per-bank busy timers; only the addressed bank goes inaccessible
    for (genvar b = 0; b < `DRBS_NUM_BANKS; b++) begin : g_bank
        assign pb_start[b] = per_bank_refresh_cmd && (ca_i[2:0] == 3'(b)); // [RQ6]
        drbs_bank_timer u_timer (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .start_i(pb_start[b]),
            .count_i(4'(`DRBS_RFCPB_CYC)),
            .busy_o(pb_busy[b]),
            .done_o(pb_done[b])
        );
    end

    // ======================================================================
    // all-bank refresh busy time
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ab_cnt_reg <= 4'h0;
        end else if (all_bank_refresh_cmd) begin
            ab_cnt_reg <= 4'(`DRBS_RFCAB_CYC);
        end else if (ab_cnt_reg != 4'h0) begin
            ab_cnt_reg <= ab_cnt_reg - 4'h1;
        end
    end

    // ======================================================================
    // bank open state: rows are not tracked, so only refresh can idle a bank
    // activates and precharges merely hold the decoder for their second edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_active_o <= 8'h00;
        end else if (all_bank_refresh_cmd) begin
            bank_active_o <= 8'h00; // [RQ15]
        end else if (dec_reg == drbs_pkg::DRBS_CAP2 && !per_bank_pend_reg) begin
            bank_active_o <= bank_active_o & ~pb_done;
        end else begin
            bank_active_o <= (bank_active_o & ~pb_done & ~pb_start); // [RQ7]
        end
    end

    // ======================================================================
    // registered status outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_count_o <= 3'h0;
            row_count_o <= 16'h0000;
            bank_busy_o <= 8'h00;
            all_bank_busy_o <= 1'b0;
            refresh_done_o <= 1'b0;
        end else begin
            bank_count_o <= bank_count_reg;
            row_count_o <= row_count_reg;
            bank_busy_o <= pb_busy | {8{ab_cnt_reg != 4'h0}}; // [RQ6]
            all_bank_busy_o <= (ab_cnt_reg != 4'h0);
            // all-bank done pulses in its last busy cycle, one ahead of the flag
            refresh_done_o <= (|pb_done) || (ab_cnt_reg == 4'h1); // [RQ7] [RQ15]
        end
    end

    // ======================================================================
    // checks
    a_bank_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13] [RQ18]
        (all_bank_refresh_cmd || self_refresh_exit_i) |=> bank_count_reg == 3'h0)
        else $error("bank counter not cleared");
    a_bank_cnt_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ19]
        (per_bank_refresh_cmd && !self_refresh_exit_i && bank_count_reg == 3'h7)
        |=> bank_count_reg == 3'h0 && row_count_reg == $past(row_count_reg) + 16'h0001)
        else $error("bank counter wrap or row advance wrong");
    a_bank_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ19]
        (per_bank_refresh_cmd && !self_refresh_exit_i)
        |=> bank_count_reg == $past(bank_count_reg) + 3'h1)
        else $error("bank counter did not step");
    a_row_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ19]
        (per_bank_refresh_cmd && !self_refresh_exit_i && bank_count_reg != 3'h7)
        |=> row_count_reg == $past(row_count_reg))
        else $error("row counter moved before the eighth bank");
    a_only_target: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        per_bank_refresh_cmd
        |=> pb_busy[target_bank_reg] && $countones(pb_busy & ~$past(pb_busy)) <= 1)
        else $error("refresh did not fence off just its target bank");
    a_busy_out: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        per_bank_refresh_cmd |=> ##1 bank_busy_o[target_bank_reg])
        else $error("target bank not flagged inaccessible");
    a_pb_busy_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
        $rose(pb_busy[0]) |-> pb_busy[0] [*3] ##1 !pb_busy[0])
        else $error("bank 0 busy length wrong");
    a_pb_done: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
        $fell(pb_busy[0]) |=> refresh_done_o)
        else $error("no done pulse after bank 0 refresh");
    a_ab_row: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ23]
        (all_bank_refresh_cmd && !self_refresh_exit_i)
        |=> row_count_reg == $past(row_count_reg) + 16'h0001)
        else $error("row not advanced after all-bank refresh");
    a_ab_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
        all_bank_refresh_cmd |=> bank_active_o == 8'h00)
        else $error("banks not idle after all-bank refresh");
    a_ab_busy: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
        all_bank_refresh_cmd |=> ##1 all_bank_busy_o [*6] ##1 !all_bank_busy_o)
        else $error("all-bank busy length wrong");
    a_ab_done: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
        all_bank_refresh_cmd |=> ##6 refresh_done_o)
        else $error("no done pulse after all-bank refresh");
endmodule : drbs_refresh_sched

//--- verification/drbs_ctrl_model.sv
// controller model: issues two-edge commands with refresh spacing kept
`timescale 1ns/1ps
`include "drbs_regs.svh"

module drbs_ctrl_model (
    input wire logic clk_i,
    output logic cs_o,
    output logic [5:0] ca_o
);
    // ==========================================================================
    // spacing, padded past the busy window so the bench sees each cycle end
    localparam int PB_GAP = `DRBS_RFCPB_CYC + 3;
    localparam int AB_GAP = `DRBS_RFCAB_CYC + 3;
    int cyc = 0;
    int last_pb = -100;
    int last_ab = -100;
    logic [2:0] mirror_count = 3'h0;

    initial begin
        cs_o = 1'b0;
        ca_o = 6'h15;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
    end

    // ==========================================================================
    // commands; the lone near-miss activate is closed by a precharge before any refresh
    task automatic issue(input logic cs, input logic [5:0] first, input logic [5:0] second,
                         input int slack);
        logic is_ref;
        is_ref = cs && (first[4:0] == `DRBS_REF_CA_CODE);
        while ((cyc - last_pb) < PB_GAP ||
               (cyc - last_ab) < AB_GAP) begin
            @(negedge clk_i);
        end
        repeat (slack) @(negedge clk_i);
        cs_o = cs;
        ca_o = first;
        @(negedge clk_i);
        cs_o = 1'b0;
        ca_o = second;
        @(negedge clk_i);
        // inverted so a decoder that samples late never sees the old bank
        ca_o = ~second;
        if (is_ref && first[5]) begin
            last_ab = cyc;
            mirror_count = 3'h0;
        end else if (is_ref) begin
            last_pb = cyc;
            mirror_count = mirror_count + 3'h1;
        end
    endtask : issue

    // reset and self-refresh exit resynchronise the count as an all-bank refresh does
    task automatic sync_mirror();
        mirror_count = 3'h0;
    endtask : sync_mirror
endmodule : drbs_ctrl_model

//--- verification/drbs_refresh_sched_tb_top.sv
// self-checking bench for the refresh bank scheduler
`timescale 1ns/1ps
`include "drbs_regs.svh"

module drbs_refresh_sched_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic self_refresh_exit_i = 1'b0;
    logic cs_i;
    logic [5:0] ca_i;
    logic [2:0] bank_count_o;
    logic [15:0] row_count_o;
    logic [7:0] bank_busy_o;
    logic [7:0] bank_active_o;
    logic all_bank_busy_o;
    logic refresh_done_o;
    int failures = 0;
    int compares = 0;
    int seed = 29;
    logic [2:0] exp_count = 3'h0;
    logic [15:0] exp_row = 16'h0000;
    logic [2:0] order [8];

    drbs_refresh_sched i_drbs_refresh_sched (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i),
        .ca_i(ca_i), .self_refresh_exit_i(self_refresh_exit_i), .bank_count_o(bank_count_o),
        .row_count_o(row_count_o), .bank_busy_o(bank_busy_o), .bank_active_o(bank_active_o),
        .all_bank_busy_o(all_bank_busy_o), .refresh_done_o(refresh_done_o));
    drbs_ctrl_model i_drbs_ctrl_model (.clk_i(clk_i), .cs_o(cs_i), .ca_o(ca_i));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ==========================================================================
    // compare and verdict
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_flag

    task automatic print_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    function automatic logic [15:0] one_hot(input logic [2:0] b);
        return 16'h0001 << b;
    endfunction : one_hot

    // ==========================================================================
    // refresh commands with their expected effects
    task automatic ref_pb(input logic [2:0] bank);
        i_drbs_ctrl_model.issue(1'b1, 6'h08, {3'($random(seed)), bank}, {$random(seed)} % 3);
        exp_count = exp_count + 3'h1;
        if (exp_count == 3'h0) begin
            exp_row = exp_row + 16'h0001;
        end
        for (int i = 0; i < `DRBS_RFCPB_CYC; i++) begin
            @(negedge clk_i);
            check_val(16'(bank_busy_o), one_hot(bank));
        end
        check_val(16'(bank_count_o), 16'(exp_count));
        check_val(16'(bank_count_o), 16'(i_drbs_ctrl_model.mirror_count));
        check_val(row_count_o, exp_row);
        @(negedge clk_i);
        check_val(16'(bank_busy_o), 16'h0000);
        check_flag(refresh_done_o, 1'b1);
        check_val(16'(bank_active_o), 16'h0000);
    endtask : ref_pb

    task automatic ref_ab();
        i_drbs_ctrl_model.issue(1'b1, 6'h28, 6'($random(seed)), {$random(seed)} % 3);
        exp_count = 3'h0;
        exp_row = exp_row + 16'h0001;
        // all-bank status leads per-bank by one edge: there is no bank to capture
        check_flag(all_bank_busy_o, 1'b1);
        for (int i = 1; i < `DRBS_RFCAB_CYC; i++) begin
            @(negedge clk_i);
            check_flag(all_bank_busy_o, 1'b1);
        end
        check_val(16'(bank_count_o), 16'h0000);
        check_val(row_count_o, exp_row);
        check_flag(refresh_done_o, 1'b1);
        @(negedge clk_i);
        check_flag(all_bank_busy_o, 1'b0);
        check_flag(refresh_done_o, 1'b0);
        check_val(16'(bank_active_o), 16'h0000);
    endtask : ref_ab

    // near misses of the refresh code must change nothing
    task automatic bad_cmd(input logic cs, input logic [5:0] first);
        i_drbs_ctrl_model.issue(cs, first, 6'h07, 0);
        repeat (3) @(negedge clk_i);
        check_val(16'(bank_busy_o), 16'h0000);
        check_val(16'(bank_count_o), 16'(exp_count));
        check_flag(all_bank_busy_o, 1'b0);
    endtask : bad_cmd

    // ==========================================================================
    // main sequence
    initial begin
        int j;
        logic [2:0] tmp;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        check_val(16'(bank_count_o), 16'h0000);
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 8; i++) order[i] = 3'(i);
            for (int i = 7; i > 0; i--) begin
                j = {$random(seed)} % (i + 1);
                tmp = order[i];
                order[i] = order[j];
                order[j] = tmp;
            end
            // last set stops short so the all-bank refresh meets a nonzero count
            for (int i = 0; i < ((s == 3) ? 5 : 8); i++) ref_pb(order[i]);
        end
        ref_ab();
        ref_ab();
        ref_pb(3'h7);
        bad_cmd(1'b0, 6'h08);
        bad_cmd(1'b1, 6'h09);
        bad_cmd(1'b1, 6'h10);
        bad_cmd(1'b1, 6'h0C);
        bad_cmd(1'b1, 6'h18);
        bad_cmd(1'b1, 6'h00);
        self_refresh_exit_i = 1'b1;
        @(negedge clk_i);
        self_refresh_exit_i = 1'b0;
        @(negedge clk_i);
        exp_count = 3'h0;
        i_drbs_ctrl_model.sync_mirror();
        check_val(16'(bank_count_o), 16'h0000);
        check_val(row_count_o, exp_row);
        ref_pb(3'h5);
        rst_i = 1'b1;
        #5 check_val(16'(bank_count_o), 16'h0000);
        check_val(row_count_o, 16'h0000);
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        i_drbs_ctrl_model.sync_mirror();
        exp_count = 3'h0;
        exp_row = 16'h0000;
        ref_pb(3'h2);
        ref_ab();
        print_verdict();
    end

    // budget is about sixteen times the expected run
    initial begin
        #(6000 * 50);
        failures++;
        print_verdict();
    end
endmodule : drbs_refresh_sched_tb_top
